// ---- src/modem_host_port.v ----
// Host serial port and channel command interpreter of the radio modem
`include "modem_defines.vh"
module modem_host_port #(
  parameter RESET_HOLD_CYC = `RESET_HOLD_CYC_DFLT
) (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       rxd,
  output reg        txd,
  output reg        rts,
  input  wire       cts,
  input  wire       mode_sel,
  input  wire       reset_pin_n,
  input  wire       settings_init_pin_n,
  input  wire [2:0] baud_sel,
  input  wire       two_stop,
  output reg        command_mode,
  output reg  [5:0] channel,
  output reg        defaults_restored,
  output wire       internal_reset,
  output wire [7:0] air_tx_data,
  output wire       air_tx_valid,
  input  wire       air_tx_ready,
  input  wire       air_tx_busy,
  input  wire [7:0] air_rx_data,
  input  wire       air_rx_valid,
  output wire       air_rx_ready,
  input  wire       air_rx_good,
  output reg        transmit_indicator,
  output reg        receive_indicator
);
  localparam [15:0] HOLD_LIM = RESET_HOLD_CYC[15:0];
  localparam [3:0] RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8;
  localparam [3:0] TX_IDLE = 4'h1, TX_START = 4'h2, TX_DATA = 4'h4, TX_STOP = 4'h8;
  localparam [6:0] P_AT = 7'h01, P_C = 7'h02, P_H = 7'h04, P_D1 = 7'h08;
  localparam [6:0] P_D2 = 7'h10, P_CR = 7'h20, P_LF = 7'h40;

  // Hex digit to {valid, nibble}
  function [4:0] hex_val;
    input [7:0] c;
    begin
      if (c >= `CHR_0 && c <= `CHR_9) hex_val = {1'b1, c[3:0]};
      else if (c >= `CHR_A_UP && c <= `CHR_F_UP) hex_val = {1'b1, c[3:0] + 4'h9};
      else if (c >= `CHR_A_LO && c <= `CHR_F_LO) hex_val = {1'b1, c[3:0] + 4'h9};
      else hex_val = 5'h00;
    end
  endfunction

  // Nibble to upper-case ASCII hex
  function [7:0] hex_chr;
    input [3:0] n;
    begin
      if (n > 4'h9) hex_chr = {4'h0, n} + `HEX_ALPHA;
      else hex_chr = {4'h0, n} + `CHR_0;
    end
  endfunction

  // Oversample divider per selected rate
  function [11:0] baud_div;
    input [2:0] sel;
    integer d;
    begin
      case (sel)
        3'h0: d = `DIV16(`RATE_1200);
        3'h1: d = `DIV16(`RATE_2400);
        3'h2: d = `DIV16(`RATE_4800);
        3'h3: d = `DIV16(`RATE_9600);
        3'h4: d = `DIV16(`RATE_19200);
        3'h5: d = `DIV16(`RATE_38400);
        default: d = `DIV16(`RATE_57600);
      endcase
      baud_div = d[11:0] - 12'h001;
    end
  endfunction

  // Pin synchronisers: three flops, a change counts once two agree
  wire [`PIN_COUNT-1:0] pin_raw;
  wire [`PIN_COUNT-1:0] pin_f;
  assign pin_raw = {settings_init_pin_n, reset_pin_n, mode_sel, cts, rxd};
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : sy
      reg s1_q, s2_q, s3_q, f_q;
      always @(posedge mclk) begin
        if (!rst_n) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          f_q  <= 1'b1;
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) f_q <= s2_q;
        end
      end
      assign pin_f[gi] = f_q;
    end
  endgenerate

  // Reset pin must stay low for the full hold time
  reg [15:0] hold_cnt_q;
  reg        hold_rst_q;
  always @(posedge mclk) begin
    if (!rst_n) begin
      hold_cnt_q <= 16'h0000;
      hold_rst_q <= 1'b0;
    end else if (pin_f[`PIN_RST]) begin
      hold_cnt_q <= 16'h0000;
      hold_rst_q <= 1'b0;
    end else if (hold_cnt_q == HOLD_LIM) begin
      hold_rst_q <= 1'b1;
    end else begin
      hold_cnt_q <= hold_cnt_q + 16'h0001;
    end
  end
  wire srst_n = rst_n & ~hold_rst_q;
  assign internal_reset = hold_rst_q;

  // Init pin sampled once, after the filter needs four edges to reach the pin level
  reg [4:0] settle_q;
  always @(posedge mclk) begin
    if (!rst_n) begin
      settle_q          <= 5'h00;
      defaults_restored <= 1'b0;
    end else begin
      settle_q <= {settle_q[3:0], 1'b1};
      if (settle_q == `INIT_SETTLE) defaults_restored <= ~pin_f[`PIN_INIT];
    end
  end

  // Oversample tick
  reg [11:0] div_q;
  wire       tick = (div_q == 12'h000);
  always @(posedge mclk) begin
    if (!srst_n) div_q <= 12'h000;
    else if (tick) div_q <= baud_div(baud_sel);
    else div_q <= div_q - 12'h001;
  end

  // Receiver: 8N1 characters from the host
  reg [3:0] rx_st_q;
  reg [3:0] rx_tk_q;
  reg [2:0] rx_bit_q;
  reg [7:0] rx_sh_q;
  reg       rx_done_q;
  always @(posedge mclk) begin
    if (!srst_n) begin
      rx_st_q   <= RX_IDLE;
      rx_tk_q   <= 4'h0;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (tick) begin
        rx_tk_q <= rx_tk_q + 4'h1;
        case (rx_st_q)
          RX_IDLE: begin
            rx_tk_q <= 4'h0;
            if (!pin_f[`PIN_RXD]) rx_st_q <= RX_START;
          end
          RX_START: begin
            if (rx_tk_q == `MID_SAMPLE) begin
              rx_tk_q  <= 4'h0;
              rx_bit_q <= 3'h0;
              rx_st_q  <= pin_f[`PIN_RXD] ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_tk_q == `LAST_TICK) begin
              rx_sh_q <= {pin_f[`PIN_RXD], rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == `LAST_BIT) rx_st_q <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_tk_q == `LAST_TICK) begin
              rx_done_q <= pin_f[`PIN_RXD];
              rx_st_q   <= RX_IDLE;
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

  // Mode follows the filtered pin
  always @(posedge mclk) begin
    if (!srst_n) command_mode <= 1'b1;
    else command_mode <= pin_f[`PIN_MODE];
  end

  // Host payload buffered toward the radio in data mode
  wire fifo_in_ready;
  byte_fifo #(
    .W  (`DATA_W),
    .D  (`FIFO_DEPTH),
    .AW (`FIFO_AW)
  ) u_fifo (
    .mclk        (mclk),
    .srst_n      (srst_n),
    .in_data     (rx_sh_q),
    .in_valid    (rx_done_q & ~command_mode),
    .in_ready    (fifo_in_ready),
    .out_data_q  (air_tx_data),
    .out_valid_q (air_tx_valid),
    .out_ready   (air_tx_ready)
  );

  // Channel command parser
  reg [6:0] ps_q;
  reg [3:0] hi_q;
  reg [3:0] lo_q;
  reg       resp_start;
  wire [4:0] hv = hex_val(rx_sh_q);
  always @(posedge mclk) begin
    if (!srst_n) begin
      ps_q       <= P_AT;
      hi_q       <= 4'h0;
      lo_q       <= 4'h0;
      channel    <= `CH_DEFAULT;
      resp_start <= 1'b0;
    end else begin
      resp_start <= 1'b0;
      if (rx_done_q & command_mode) begin
        ps_q <= (rx_sh_q == `CHR_AT) ? P_C : P_AT;
        case (ps_q)
          P_C:  if (rx_sh_q == `CHR_C) ps_q <= P_H;
          P_H:  if (rx_sh_q == `CHR_H) ps_q <= P_D1;
          P_D1: if (hv[4]) begin
            hi_q <= hv[3:0];
            ps_q <= P_D2;
          end
          P_D2: if (hv[4]) begin
            lo_q <= hv[3:0];
            ps_q <= P_CR;
          end
          P_CR: if (rx_sh_q == `CHR_CR) ps_q <= P_LF;
          P_LF: if (rx_sh_q == `CHR_LF) begin
            if (hi_q <= `CH_MAX_HI) channel <= {hi_q[1:0], lo_q};
            resp_start <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Report: prefix, equals, two digits, CR, LF
  reg       resp_busy_q;
  reg [2:0] resp_idx_q;
  reg [7:0] resp_byte;
  always @* begin
    case (resp_idx_q)
      3'h0: resp_byte = `CHR_STAR;
      3'h1: resp_byte = `CHR_C;
      3'h2: resp_byte = `CHR_H;
      3'h3: resp_byte = `CHR_EQ;
      3'h4: resp_byte = hex_chr({2'b00, channel[5:4]});
      3'h5: resp_byte = hex_chr(channel[3:0]);
      3'h6: resp_byte = `CHR_CR;
      default: resp_byte = `CHR_LF;
    endcase
  end

  // Transmitter toward the host, paced by cts
  reg [3:0] tx_st_q;
  reg [3:0] tx_tk_q;
  reg [2:0] tx_bit_q;
  reg [7:0] tx_sh_q;
  reg       tx_stop2_q;
  wire tx_free  = (tx_st_q == TX_IDLE) & ~pin_f[`PIN_CTS];
  wire ld_resp  = tx_free & resp_busy_q;
  assign air_rx_ready = tx_free & ~resp_busy_q & ~command_mode;
  wire ld_air   = air_rx_ready & air_rx_valid;
  always @(posedge mclk) begin
    if (!srst_n) begin
      tx_st_q     <= TX_IDLE;
      tx_tk_q     <= 4'h0;
      tx_bit_q    <= 3'h0;
      tx_sh_q     <= 8'h00;
      tx_stop2_q  <= 1'b0;
      txd         <= 1'b1;
      resp_busy_q <= 1'b0;
      resp_idx_q  <= 3'h0;
    end else begin
      if (resp_start) begin
        resp_busy_q <= 1'b1;
        resp_idx_q  <= 3'h0;
      end else if (ld_resp) begin
        resp_idx_q <= resp_idx_q + 3'h1;
        if (resp_idx_q == `LAST_BIT) resp_busy_q <= 1'b0;
      end
      if (ld_resp | ld_air) begin
        tx_sh_q    <= ld_resp ? resp_byte : air_rx_data;
        tx_stop2_q <= two_stop;
        tx_tk_q    <= 4'h0;
        tx_st_q    <= TX_START;
        txd        <= 1'b0;
      end else if (tick) begin
        tx_tk_q <= tx_tk_q + 4'h1;
        if (tx_tk_q == `LAST_TICK) begin
          case (tx_st_q)
            TX_START: begin
              tx_st_q  <= TX_DATA;
              tx_bit_q <= 3'h0;
              txd      <= tx_sh_q[0];
            end
            TX_DATA: begin
              tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
              tx_bit_q <= tx_bit_q + 3'h1;
              txd      <= (tx_bit_q == `LAST_BIT) ? 1'b1 : tx_sh_q[1];
              if (tx_bit_q == `LAST_BIT) tx_st_q <= TX_STOP;
            end
            TX_STOP: begin
              if (tx_stop2_q) tx_stop2_q <= 1'b0;
              else tx_st_q <= TX_IDLE;
            end
            default: tx_st_q <= TX_IDLE;
          endcase
        end
      end
    end
  end

  // Flow control and radio activity indicators
  always @(posedge mclk) begin
    if (!srst_n) begin
      rts                <= 1'b1;
      transmit_indicator <= 1'b0;
      receive_indicator  <= 1'b0;
    end else begin
      rts                <= command_mode ? (resp_busy_q | resp_start) : ~fifo_in_ready;
      transmit_indicator <= air_tx_busy;
      receive_indicator  <= air_rx_good;
    end
  end
endmodule // modem_host_port

// ---- src/modem_defines.vh ----
// Constants for the radio modem host port
// What this block does
// - Payload moves as async serial: host rxd into the modem, txd out to host.
// - Transmit indicator is on exactly while the radio is sending over the air. The code registers air_tx_busy, so the indicator lags by one mclk cycle.
// - Receive indicator is on only while valid received data is handled.
// - Reset pin low for 1 ms resets the controller; host holds it that long.
// - Init pin low at power-up restores defaults, effective at next power-up.
// - Mode pin high selects command mode; low selects the configured data mode.
// - Modem sends on txd only while cts is low; host raises cts when full. Code checks cts only when a character starts.
// - Rts low means ready for input, high means busy; host then holds off.
// - Channel command is prefix, two ASCII hex digits, then CR and LF.
// - Channels 0 to 63 accepted, 433.200 MHz to 434.775 MHz in even steps.
// - Modem answers with report prefix, equals, two hex digits, CR, LF.
// - Characters are eight data bits, no parity, one or two stop bits.
// - Link runs at a selectable rate from 1200 to 57600 bit/s.
`ifndef MODEM_DEFINES_VH
`define MODEM_DEFINES_VH
`define CLK_HZ          40000000
`define OVERSAMPLE      16
`define DIV16(r)        (`CLK_HZ / (`OVERSAMPLE * (r)))
`define RATE_1200       1200
`define RATE_2400       2400
`define RATE_4800       4800
`define RATE_9600       9600
`define RATE_19200      19200
`define RATE_38400      38400
`define RATE_57600      57600
`define RESET_HOLD_US   1000
`define RESET_HOLD_CYC_DFLT ((`CLK_HZ / 1000000) * `RESET_HOLD_US)
`define INIT_SETTLE     5'h0F
`define MID_SAMPLE      4'h7
`define LAST_TICK       4'hF
`define LAST_BIT        3'h7
`define CH_MAX_HI       4'h3
`define CH_DEFAULT      6'h00
`define DATA_W          8
`define FIFO_DEPTH      8
`define FIFO_AW         3
`define CHR_AT          8'h40
`define CHR_C           8'h43
`define CHR_H           8'h48
`define CHR_STAR        8'h2A
`define CHR_EQ          8'h3D
`define CHR_CR          8'h0D
`define CHR_LF          8'h0A
`define CHR_0           8'h30
`define CHR_9           8'h39
`define CHR_A_UP        8'h41
`define CHR_F_UP        8'h46
`define CHR_A_LO        8'h61
`define CHR_F_LO        8'h66
`define HEX_ALPHA       8'h37
`define HEX_ALPHA_LO    8'h57
`define PIN_RXD         0
`define PIN_CTS         1
`define PIN_MODE        2
`define PIN_RST         3
`define PIN_INIT        4
`define PIN_COUNT       5
`endif

// ---- src/byte_fifo.v ----
// Small FIFO with a registered output stage
module byte_fifo #(
  parameter W  = 8,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire         mclk,
  input  wire         srst_n,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output reg  [W-1:0] out_data_q,
  output reg          out_valid_q,
  input  wire         out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  // Full and empty from the word count
  assign in_ready = (cnt_q != D[AW:0]);
  assign push     = in_valid & in_ready;
  assign pop      = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);

  // Storage writes
  always @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers, count and output register
  always @(posedge mclk) begin
    if (!srst_n) begin
      wr_q        <= {AW{1'b0}};
      rd_q        <= {AW{1'b0}};
      cnt_q       <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q  <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q       <= rd_q + 1'b1;
        out_data_q <= mem[rd_q];
      end
      if (pop) begin
        out_valid_q <= 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // byte_fifo

// ---- tb/host_uart_model.sv ----
// Host serial port model: sends characters on rxd, collects characters from txd
module host_uart_model #(
  parameter int BIT = 688
) (
  input  wire logic mclk,
  input  wire logic txd,
  input  wire logic rts,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];

  // Line idles high, driven high from time zero
  initial rxd = 1'b1;

  // One character, LSB first, one stop bit, once rts is low or after 2000 cycles of waiting
  task automatic send_byte(input logic [7:0] b);
    int i;
    for (i = 0; i < 2000 && rts !== 1'b0; i++) @(negedge mclk);
    rxd = 1'b0;
    repeat (BIT) @(negedge mclk);
    for (i = 0; i < 8; i++) begin
      rxd = b[i];
      repeat (BIT) @(negedge mclk);
    end
    rxd = 1'b1;
    repeat (BIT) @(negedge mclk);
  endtask

  // Receiver samples each bit centre and queues the character
  always begin : rx_side
    logic [7:0] v;
    int         k;
    @(negedge txd);
    repeat (BIT / 2) @(negedge mclk);
    for (k = 0; k < 8; k++) begin
      repeat (BIT) @(negedge mclk);
      v[k] = txd;
    end
    repeat (BIT) @(negedge mclk);
    got.push_back(v);
  end
endmodule // host_uart_model

// ---- tb/modem_host_port_props.sv ----
// Concurrent checks on the modem host port pins
module modem_host_port_props #(
  parameter int RESET_HOLD_CYC = 20
) (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       txd,
  input wire logic       rts,
  input wire logic       cts,
  input wire logic       reset_pin_n,
  input wire logic       command_mode,
  input wire logic [5:0] channel,
  input wire logic       internal_reset,
  input wire logic [7:0] air_tx_data,
  input wire logic       air_tx_valid,
  input wire logic       air_tx_ready,
  input wire logic       air_tx_busy,
  input wire logic       air_rx_ready,
  input wire logic       air_rx_good,
  input wire logic       transmit_indicator,
  input wire logic       receive_indicator
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [15:0] low_q;

  // Cycles the reset pin has stayed low
  always_ff @(posedge mclk) begin
    if (!rst_n || reset_pin_n) low_q <= 16'h0000;
    else if (low_q != 16'hFFFF) low_q <= low_q + 16'h0001;
  end

  sequence run_on;
    $past(rst_n) && !$past(internal_reset);
  endsequence
  sequence cts_held;
    cts [*6];
  endsequence
  sequence tx_stall;
    air_tx_valid && !air_tx_ready;
  endsequence
  sequence data_idle;
    !command_mode && !internal_reset ##1 !internal_reset;
  endsequence

  AST_TXI: assert property (run_on |-> transmit_indicator == $past(air_tx_busy))
    else $error("transmit indicator does not follow radio busy");
  AST_RXI: assert property (run_on |-> receive_indicator == $past(air_rx_good))
    else $error("receive indicator does not follow good reception");
  AST_CTS_HOLD: assert property (cts_held |=> !$fell(txd))
    else $error("txd started while cts high");
  AST_RST_VAL: assert property ($rose(rst_n) |-> rts && txd && channel == 6'h00)
    else $error("wrong pin levels out of reset");
  AST_CH_MODE: assert property (data_idle |-> $stable(channel))
    else $error("channel changed outside command mode");
  AST_IRST_LATE: assert property (int'(low_q) > RESET_HOLD_CYC + 8 |-> internal_reset)
    else $error("internal reset missing after long low");
  AST_IRST_EARLY: assert property ($rose(internal_reset) |-> int'(low_q) >= RESET_HOLD_CYC)
    else $error("internal reset after too short low");
  AST_AIR_HOLD: assert property (tx_stall |=> air_tx_valid && $stable(air_tx_data))
    else $error("radio payload dropped while stalled");
  AST_RX_CMD: assert property (command_mode |-> !air_rx_ready)
    else $error("radio data accepted in command mode");
endmodule // modem_host_port_props

bind modem_host_port modem_host_port_props #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) chk (
  .mclk(mclk), .rst_n(rst_n), .txd(txd), .rts(rts), .cts(cts),
  .reset_pin_n(reset_pin_n), .command_mode(command_mode), .channel(channel),
  .internal_reset(internal_reset), .air_tx_data(air_tx_data),
  .air_tx_valid(air_tx_valid), .air_tx_ready(air_tx_ready), .air_tx_busy(air_tx_busy),
  .air_rx_ready(air_rx_ready), .air_rx_good(air_rx_good),
  .transmit_indicator(transmit_indicator), .receive_indicator(receive_indicator));

// ---- tb/modem_host_port_bench.sv ----
// Self-checking bench for the modem host port
module modem_host_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  logic       mclk, rst_n, cts, mode_sel, reset_pin_n, settings_init_pin_n, two_stop;
  logic       air_tx_ready, air_tx_busy, air_rx_valid, air_rx_good;
  logic [7:0] air_rx_data;
  wire        rxd, txd, rts, command_mode, defaults_restored, internal_reset;
  wire        air_tx_valid, air_rx_ready, transmit_indicator, receive_indicator;
  wire  [5:0] channel;
  wire  [7:0] air_tx_data;
  int         fails, total_checks, i;
  logic [7:0] cmd [7] = '{8'h40, 8'h43, 8'h48, 8'h31, 8'h46, 8'h0D, 8'h0A};
  logic [7:0] rep [8] = '{8'h2A, 8'h43, 8'h48, 8'h3D, 8'h31, 8'h46, 8'h0D, 8'h0A};

  modem_host_port #(.RESET_HOLD_CYC(HOLD)) uut (
    .mclk(mclk), .rst_n(rst_n), .rxd(rxd), .txd(txd), .rts(rts), .cts(cts),
    .mode_sel(mode_sel), .reset_pin_n(reset_pin_n),
    .settings_init_pin_n(settings_init_pin_n), .baud_sel(3'h6), .two_stop(two_stop),
    .command_mode(command_mode), .channel(channel), .defaults_restored(defaults_restored),
    .internal_reset(internal_reset), .air_tx_data(air_tx_data),
    .air_tx_valid(air_tx_valid), .air_tx_ready(air_tx_ready), .air_tx_busy(air_tx_busy),
    .air_rx_data(air_rx_data), .air_rx_valid(air_rx_valid), .air_rx_ready(air_rx_ready),
    .air_rx_good(air_rx_good), .transmit_indicator(transmit_indicator),
    .receive_indicator(receive_indicator));

  host_uart_model host (.mclk(mclk), .txd(txd), .rts(rts), .rxd(rxd));

  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic report_and_stop;
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Hang guard
  initial begin
    ticks(125000);
    fails++;
    report_and_stop;
  end

  // Test sequence
  initial begin
    rst_n = 1'b0;
    cts = 1'b1;
    mode_sel = 1'b1;
    reset_pin_n = 1'b1;
    settings_init_pin_n = 1'b0;
    two_stop = 1'b0;
    air_tx_ready = 1'b0;
    air_tx_busy = 1'b0;
    air_rx_valid = 1'b0;
    air_rx_good = 1'b0;
    air_rx_data = 8'h00;
    ticks(4);
    rst_n = 1'b1;
    ticks(10);
    check("defaults", {7'h00, defaults_restored}, 8'h01);
    check("channel", {2'h0, channel}, 8'h00);
    check("cmd mode", {7'h00, command_mode}, 8'h01);
    check("rts ready", {7'h00, rts}, 8'h00);
    settings_init_pin_n = 1'b1;
    for (i = 1; i >= 0; i--) begin
      air_tx_busy = i[0];
      air_rx_good = i[0];
      ticks(2);
      check("tx ind", {7'h00, transmit_indicator}, {7'h00, i[0]});
      check("rx ind", {7'h00, receive_indicator}, {7'h00, i[0]});
    end
    for (i = 0; i < 7; i++) host.send_byte(cmd[i]);
    ticks(50);
    check("channel", {2'h0, channel}, 8'h1F);
    check("txd held", {7'h00, txd}, 8'h01);
    check("rts busy", {7'h00, rts}, 8'h01);
    cts = 1'b0;
    // Data-mode payload goes in while the report is still going out
    mode_sel = 1'b0;
    ticks(10);
    check("cmd mode", {7'h00, command_mode}, 8'h00);
    host.send_byte(8'hA5);
    for (i = 0; i < 2000 && air_tx_valid !== 1'b1; i++) @(negedge mclk);
    check("air tx", air_tx_data, 8'hA5);
    ticks(3);
    air_tx_ready = 1'b1;
    ticks(1);
    air_tx_ready = 1'b0;
    check("air valid", {7'h00, air_tx_valid}, 8'h00);
    for (i = 0; i < 70000 && host.got.size() < 8; i++) @(negedge mclk);
    for (i = 0; i < 8; i++) check("report", host.got[i], rep[i]);
    // Radio byte to host with two stop bits: start, 8 data, 2 stop
    air_rx_data = 8'h3C;
    two_stop = 1'b1;
    air_rx_valid = 1'b1;
    for (i = 0; i < 2000 && air_rx_ready !== 1'b1; i++) @(negedge mclk);
    ticks(1);
    air_rx_valid = 1'b0;
    for (i = 0; i < 9000 && air_rx_ready !== 1'b1; i++) @(negedge mclk);
    check("frame bits", (i + host.BIT / 2) / host.BIT, 8'h0B);
    for (i = 0; i < 9000 && host.got.size() < 9; i++) @(negedge mclk);
    check("air rx", host.got[8], 8'h3C);
    reset_pin_n = 1'b0;
    ticks(10);
    check("short low", {7'h00, internal_reset}, 8'h00);
    ticks(HOLD + 2);
    check("long low", {7'h00, internal_reset}, 8'h01);
    check("channel", {2'h0, channel}, 8'h00);
    reset_pin_n = 1'b1;
    ticks(10);
    check("released", {7'h00, internal_reset}, 8'h00);
    report_and_stop;
  end
endmodule // modem_host_port_bench
